// File: design/org_guard.sv
/*
  oscillator range transition guard: holds the range, step and
  modulation fields and changes them along safe paths for guarded
  requests; direct writes made while idle are taken as written, even when unsafe.
  assumes all request inputs come from logic on the same clock and
  that a request is a one-cycle pulse.
*/
`timescale 1ns/1ns
module org_guard (
  input wire logic clk,
  input wire logic resetn,
  input wire logic range_req,
  input wire logic [3:0] range_target,
  input wire logic freq_req,
  input wire logic [2:0] freq_step_in,
  input wire logic [4:0] mod_in,
  input wire logic raw_we,
  input wire logic [3:0] raw_range,
  input wire logic [2:0] raw_step,
  input wire logic [4:0] raw_mod,
  output logic [3:0] range_select_value,
  output logic [2:0] frequency_step_field,
  output logic [4:0] modulation_select_field,
  output logic busy,
  output logic osc_halted,
  output logic osc_fault,
  output logic startup_safe
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  org_pkg::org_state_t state;
  org_pkg::org_state_t next_state;
  logic [3:0] goal;
  logic [3:0] next_goal;
  logic [3:0] restore;
  logic [3:0] next_restore;
  logic freq_pend;
  logic next_freq_pend;
  logic [2:0] step_hold;
  logic [2:0] next_step_hold;
  logic [4:0] mod_hold;
  logic [4:0] next_mod_hold;
  logic [3:0] next_range;
  logic [2:0] next_step;
  logic [4:0] next_mod;
  logic next_fault;
  logic next_startup;
  logic [org_pkg::TICK_W-1:0] tick_cnt;
  logic [org_pkg::TICK_W-1:0] next_tick_cnt;
  logic step_tick;
  logic dead_start;
  logic raw_take;
  logic raw_range_haz;
  logic raw_freq_haz;

  // ----------------------------------------------------------------
  // step enable divider, one pulse per settle interval
  // ----------------------------------------------------------------
  always_comb begin
    next_tick_cnt = tick_cnt + 1'b1;
    if (state == org_pkg::ORG_IDLE ||
        tick_cnt == org_pkg::TICK_W'(org_pkg::STEP_CYCLES - 1)) begin
      next_tick_cnt = '0;
    end
  end

  assign step_tick =
    (tick_cnt == org_pkg::TICK_W'(org_pkg::STEP_CYCLES - 1));

  // register the divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ----------------------------------------------------------------
  // direct writes bypass the walker and are checked for hazards
  // ----------------------------------------------------------------
  assign raw_take = raw_we && (state == org_pkg::ORG_IDLE);
  assign raw_range_haz = org_pkg::org_hazard(range_select_value, raw_range);
  assign raw_freq_haz = (range_select_value == org_pkg::RANGE_MAX) &&
                        (raw_step != frequency_step_field ||
                         raw_mod != modulation_select_field);
  assign dead_start = raw_take && (raw_range_haz || raw_freq_haz);

  // ----------------------------------------------------------------
  // sequencer and output fields
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_goal = goal;
    next_restore = restore;
    next_freq_pend = freq_pend;
    next_step_hold = step_hold;
    next_mod_hold = mod_hold;
    next_range = range_select_value;
    next_step = frequency_step_field;
    next_mod = modulation_select_field;
    next_fault = osc_fault;
    next_startup = startup_safe;
    unique case (state)
      org_pkg::ORG_IDLE: begin
        if (raw_take) begin
          next_range = raw_range;
          next_step = raw_step;
          next_mod = raw_mod;
        end else if (range_req && range_target != range_select_value) begin
          next_goal = range_target;
          next_state = org_pkg::ORG_WALK;
        end else if (freq_req) begin
          next_step_hold = freq_step_in;
          next_mod_hold = mod_in;
          if (range_select_value == org_pkg::RANGE_MAX) begin
            next_goal = org_pkg::RANGE_DEFAULT;
            next_restore = org_pkg::RANGE_MAX;
            next_freq_pend = 1'b1;
            next_state = org_pkg::ORG_WALK;
          end else begin
            next_step = freq_step_in;
            next_mod = mod_in;
          end
        end
      end
      org_pkg::ORG_WALK: begin
        if (step_tick) begin
          if (range_select_value < goal) begin
            next_range = range_select_value + 1'b1;
          end else if (range_select_value > goal) begin
            next_range = range_select_value - 1'b1;
          end
          if (next_range == goal) begin
            next_state = freq_pend ? org_pkg::ORG_FREQ : org_pkg::ORG_IDLE;
          end
        end
      end
      org_pkg::ORG_FREQ: begin
        next_step = step_hold;
        next_mod = mod_hold;
        next_freq_pend = 1'b0;
        next_goal = restore;
        next_state = org_pkg::ORG_WALK;
      end
    endcase
    if (dead_start && osc_halted) begin
      next_fault = 1'b1;
    end
    if (next_range != range_select_value) begin
      next_startup = 1'b0;
    end
  end

  // register sequencer and fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= org_pkg::ORG_IDLE;
      goal <= org_pkg::RANGE_DEFAULT;
      restore <= org_pkg::RANGE_DEFAULT;
      freq_pend <= 1'b0;
      step_hold <= org_pkg::STEP_RESET;
      mod_hold <= org_pkg::MOD_RESET;
      range_select_value <= org_pkg::RANGE_DEFAULT;
      frequency_step_field <= org_pkg::STEP_RESET;
      modulation_select_field <= org_pkg::MOD_RESET;
      osc_fault <= 1'b0;
      startup_safe <= 1'b1;
    end else begin
      state <= next_state;
      goal <= next_goal;
      restore <= next_restore;
      freq_pend <= next_freq_pend;
      step_hold <= next_step_hold;
      mod_hold <= next_mod_hold;
      range_select_value <= next_range;
      frequency_step_field <= next_step;
      modulation_select_field <= next_mod;
      osc_fault <= next_fault;
      startup_safe <= next_startup;
    end
  end

  assign busy = (state != org_pkg::ORG_IDLE);

  // halt model for unsafe direct writes
  org_dead_timer u_dead (
    .clk(clk),
    .resetn(resetn),
    .start(dead_start),
    .active(osc_halted)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence walk_start_s;
    state == org_pkg::ORG_IDLE && range_req && !raw_we &&
      range_target != range_select_value;
  endsequence

  sequence busy_hold_s;
    busy [*8];
  endsequence

  walk_busy_a: assert property (@(posedge clk) disable iff (!resetn)
    walk_start_s |=> busy_hold_s)
    else $error("busy not held during walk");

  walk_single_a: assert property (@(posedge clk) disable iff (!resetn)
    busy && !raw_we |=> (range_select_value == $past(range_select_value))
      || (range_select_value == $past(range_select_value) + 4'h1)
      || (range_select_value == $past(range_select_value) - 4'h1))
    else $error("walker jumped more than one step");

  // walker steps never cross the gap
  walk_safe_a: assert property (@(posedge clk) disable iff (!resetn)
    busy |=> !org_pkg::org_hazard($past(range_select_value),
                                  range_select_value))
    else $error("walker made an unsafe range move");

  raw_halt_a: assert property (@(posedge clk) disable iff (!resetn)
    raw_take && org_pkg::org_hazard(range_select_value, raw_range)
      |=> osc_halted [*4])
    else $error("no halt after unsafe range write");

  raw_safe_a: assert property (@(posedge clk) disable iff (!resetn)
    raw_take && !osc_halted && range_select_value <= org_pkg::RANGE_MID &&
      raw_range < org_pkg::RANGE_LOW_EDGE |=> !osc_halted)
    else $error("halt after a permitted direct write");

  top_field_a: assert property (@(posedge clk) disable iff (!resetn)
    raw_take && range_select_value == org_pkg::RANGE_MAX &&
      (raw_step != frequency_step_field ||
       raw_mod != modulation_select_field) |=> osc_halted)
    else $error("no halt after field change at top range");

  fault_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
    osc_fault |=> osc_fault)
    else $error("fault flag dropped");

  fault_set_a: assert property (@(posedge clk) disable iff (!resetn)
    dead_start && osc_halted |=> osc_fault)
    else $error("fault missed on overlapping halt");

  // top range freq request drops first
  top_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    state == org_pkg::ORG_IDLE && !raw_we && !range_req && freq_req &&
      range_select_value == org_pkg::RANGE_MAX
      |=> busy ##1 frequency_step_field == $past(frequency_step_field, 2))
    else $error("fields changed before leaving top range");

  startup_end_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(range_select_value) |-> !startup_safe)
    else $error("start-up window open after range change");
endmodule

// File: design/org_pkg.sv
/*
  constants shared by the oscillator range transition guard.
  assumes a 100 mhz system clock and the range walker in org_guard.
*/
// What this block does
// - a range move across the gap, from 11 or below to 14 or above or back, makes the oscillator halt for a dead time.
// - a hazardous move made while a dead time is already running is flagged as a sticky fault.
// - with all range bits set, changing the step or modulation fields also causes a dead time.
// - reset puts the range at 7, and a start-up sequence is safe only before any range change.
package org_pkg;
  // ----------------------------------------------------------------
  // field widths and reset values
  // ----------------------------------------------------------------
  localparam int RANGE_W = 4;
  localparam int STEP_W = 3;
  localparam int MOD_W = 5;
  localparam logic [3:0] RANGE_DEFAULT = 4'h7;
  localparam logic [3:0] RANGE_MAX = 4'hf;
  localparam logic [3:0] RANGE_MID = 4'hd;
  localparam logic [3:0] RANGE_LOW_EDGE = 4'hc;
  localparam logic [2:0] STEP_RESET = 3'h0;
  localparam logic [4:0] MOD_RESET = 5'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEAD_TIME_NS = 20000;
  localparam int DEAD_CYCLES = DEAD_TIME_NS / CLK_PERIOD_NS;
  localparam int DEAD_W = 11;
  localparam int STEP_SETTLE_NS = 1000;
  localparam int STEP_CYCLES =
    (STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 7;

  // ----------------------------------------------------------------
  // guard sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ORG_IDLE,
    ORG_WALK,
    ORG_FREQ
  } org_state_t;

  // true when a direct move crosses the unsafe gap
  function automatic logic org_hazard(input logic [3:0] from_r,
                                      input logic [3:0] to_r);
    org_hazard = (from_r > RANGE_MID && to_r < RANGE_LOW_EDGE) ||
                 (from_r < RANGE_LOW_EDGE && to_r > RANGE_MID);
  endfunction
endpackage

// File: design/org_dead_timer.sv
/*
  dead time timer: models the oscillator halt after an unsafe change.
  assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ns
module org_dead_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic active
);
  logic [org_pkg::DEAD_W-1:0] count;
  logic [org_pkg::DEAD_W-1:0] next_count;

  // ----------------------------------------------------------------
  // down counter, restarted by every start pulse
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (start) begin
      next_count = org_pkg::DEAD_W'(org_pkg::DEAD_CYCLES);
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  // register the count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign active = (count != '0);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // halt holds for at least 8 cycles after start
  dead_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    start |=> active [*8])
    else $error("dead time ended too early");
endmodule

// File: tb/org_guard_test.sv
/*
  self-checking bench for the oscillator range transition guard.
  assumes org_guard and org_pkg are compiled first and that the bench
  alone drives every request and data input on one 100 mhz clock.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module org_guard_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, resetn, range_req, freq_req, raw_we;
  logic [3:0] range_target, raw_range, range_select_value;
  logic [2:0] freq_step_in, raw_step, frequency_step_field;
  logic [4:0] mod_in, raw_mod, modulation_select_field;
  logic busy, osc_halted, osc_fault, startup_safe;
  int err_count = 0;
  int comparisons = 0;
  int n;

  org_guard i_dut (.clk(clk), .resetn(resetn), .range_req(range_req),
    .range_target(range_target), .freq_req(freq_req),
    .freq_step_in(freq_step_in), .mod_in(mod_in), .raw_we(raw_we),
    .raw_range(raw_range), .raw_step(raw_step), .raw_mod(raw_mod),
    .range_select_value(range_select_value),
    .frequency_step_field(frequency_step_field),
    .modulation_select_field(modulation_select_field), .busy(busy),
    .osc_halted(osc_halted), .osc_fault(osc_fault),
    .startup_safe(startup_safe));

  // clock at 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // one request pulse; kind 0 direct, 1 guarded range, 2 guarded freq
  task automatic send(input int kind, input logic [3:0] r,
                      input logic [2:0] s, input logic [4:0] m);
    @(posedge clk);
    range_target <= r;
    raw_range <= r;
    freq_step_in <= s;
    raw_step <= s;
    mod_in <= m;
    raw_mod <= m;
    raw_we <= (kind == 0);
    range_req <= (kind == 1);
    freq_req <= (kind == 2);
    @(posedge clk);
    raw_we <= 1'b0;
    range_req <= 1'b0;
    freq_req <= 1'b0;
    #1;
  endtask

  // counts edges until busy or halted falls, bounded
  task automatic wait_clear(input bit use_halt, output int cnt);
    cnt = 0;
    while (((use_halt ? osc_halted : busy) === 1'b1) && cnt < 5000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    // a limit that runs out is a mismatch
    if (cnt >= 5000) begin
      err_count++;
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    `CHK(range_select_value, org_pkg::RANGE_DEFAULT)
    `CHK({frequency_step_field, modulation_select_field}, 8'h00)
    `CHK({busy, osc_halted, osc_fault, startup_safe}, 4'h1)
    @(posedge clk);
    resetn <= 1'b1;
  endtask

  // direct write that must not halt the oscillator
  task automatic raw_safe(input logic [3:0] r, input logic [2:0] s);
    send(0, r, s, 5'h00);
    `CHK(range_select_value, r)
    `CHK(osc_halted, 1'b0)
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {range_req, freq_req, raw_we} = 3'h0;
    range_target = 4'h0;
    raw_range = 4'h0;
    {freq_step_in, raw_step} = 6'h00;
    {mod_in, raw_mod} = 10'h000;
    do_reset();
    // freq change away from the top range lands at once
    send(2, 4'h0, 3'h3, 5'h0a);
    `CHK({frequency_step_field, modulation_select_field}, {3'h3, 5'h0a})
    `CHK({busy, startup_safe}, 2'h1)
    // guarded walk 7 to 9, one step per 100 cycles
    send(1, 4'h9, 3'h3, 5'h0a);
    `CHK(busy, 1'b1)
    repeat (99) @(posedge clk);
    #1;
    `CHK(range_select_value, 4'h7)
    @(posedge clk);
    #1;
    `CHK(range_select_value, 4'h8)
    wait_clear(0, n);
    `CHK(n, 100)
    `CHK(range_select_value, 4'h9)
    `CHK({osc_halted, startup_safe}, 2'h0)
    // walk up across the gap, second request while busy is dropped
    send(1, 4'hf, 3'h3, 5'h0a);
    send(1, 4'h0, 3'h3, 5'h0a);
    wait_clear(0, n);
    `CHK(range_select_value, 4'hf)
    `CHK(osc_halted, 1'b0)
    // freq change at the top range goes through 7 and back
    send(2, 4'h0, 3'h5, 5'h11);
    `CHK(busy, 1'b1)
    wait_clear(0, n);
    `CHK({frequency_step_field, modulation_select_field}, {3'h5, 5'h11})
    `CHK(range_select_value, 4'hf)
    `CHK({osc_halted, osc_fault}, 2'h0)
    // second reset in mid-run, then direct writes
    do_reset();
    raw_safe(4'hd, 3'h0);
    `CHK(startup_safe, 1'b0)
    raw_safe(4'he, 3'h0);
    raw_safe(4'hf, 3'h0);
    // step change with all range bits set halts for 2000 cycles
    send(0, 4'hf, 3'h2, 5'h00);
    `CHK(osc_halted, 1'b1)
    wait_clear(1, n);
    `CHK(n, 2000)
    raw_safe(4'he, 3'h2);
    raw_safe(4'hd, 3'h2);
    raw_safe(4'hc, 3'h2);
    raw_safe(4'h0, 3'h2);
    // gap crossing upwards, then downwards while still halted
    send(0, 4'hf, 3'h2, 5'h00);
    `CHK({osc_halted, osc_fault}, 2'h2)
    send(0, 4'h3, 3'h2, 5'h00);
    `CHK({osc_halted, osc_fault}, 2'h3)
    wait_clear(1, n);
    `CHK(n, 2000)
    `CHK(osc_fault, 1'b1)
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
